// file: hdl/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
	// ============================================================
	// Port addresses
	localparam logic [15:0] PORT_BYPASS      = 16'h00ec;
	localparam logic [15:0] PORT_FAST_A20    = 16'h00ee;
	localparam logic [15:0] PORT_QUICK_RST   = 16'h00ef;
	localparam logic [15:0] PORT_PARITY      = 16'h00f2;
	localparam logic [15:0] PORT_WIN_CLOSE   = 16'h00f9;
	localparam logic [15:0] PORT_WIN_OPEN    = 16'h00fb;
	localparam logic [15:0] PORT_CLK_CTRL    = 16'h1072;
	localparam logic [15:0] PORT_CACHE_CTRL  = 16'hc472;
	localparam logic [15:0] PORT_REGION2     = 16'hcc72;
	localparam logic [15:0] PORT_UNLOCK_KEY  = 16'hf073;
	localparam logic [15:0] PORT_LOCK_STATE  = 16'hfc72;

	// ============================================================
	// Unlock values
	localparam logic [7:0]  UNLOCK_KEY_VAL   = 8'hda;
	localparam logic [15:0] UNLOCK_CONF_VAL  = 16'hda00;

	// ============================================================
	// Field positions and reset values
	localparam int          PARITY_SEL_BIT   = 6;
	localparam int          FREQ_SHIFT_BIT   = 15;
	localparam int          PWR_INTR_BIT     = 13;
	localparam int          INTR_END_BIT     = 1;
	localparam int          LOCK_STATE_BIT   = 0;
	localparam logic        CTRL_BIT_RST     = 1'b0;
	localparam logic [15:0] RDATA_ZERO       = 16'h0000;

	// ============================================================
	// Protected RAM window bounds
	localparam logic [23:0] WIN_LOW_ADDR     = 24'h0f0000;
	localparam logic [23:0] WIN_HIGH_ADDR    = 24'h0f0fff;

	// ============================================================
	// Chip select codes and timing
	localparam logic [4:0]  CS_PARITY_CODE   = 5'h1f;
	localparam logic [4:0]  CS_IDLE_CODE     = 5'h00;
	localparam int          QUICK_RST_CYCLES = 16;

	// Frequency shift handshake states
	typedef enum logic [1:0] {
		FS_IDLE  = 2'b00,
		FS_WAIT  = 2'b01,
		FS_APPLY = 2'b10
	} sfp_fs_e;
endpackage
`default_nettype wire

// file: hdl/sfp_pulse.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Fixed length pulse generator; a start during a pulse restarts it
module sfp_pulse #(
	parameter int LEN = 16
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic start,
	output logic      pulse_q
);
	localparam int CW = $clog2(LEN + 1);
	localparam logic [CW-1:0] LEN_C = CW'(LEN);
	localparam logic [CW-1:0] ONE_C = CW'(1);
	logic [CW-1:0] cnt_q;

	// Count down remaining high cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q   <= '0;
			pulse_q <= 1'b0;
		end else if (start) begin
			cnt_q   <= LEN_C - ONE_C;
			pulse_q <= 1'b1;
		end else if (cnt_q != '0) begin
			cnt_q   <= cnt_q - ONE_C;
		end else begin
			pulse_q <= 1'b0;
		end
	end
endmodule // sfp_pulse
`default_nettype wire

// file: hdl/sfp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Two stage synchroniser for pin inputs
module sfp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // sfp_sync
`default_nettype wire

// file: hdl/sfp_top.sv
// Functional notes
// - Unlock: key DA to F073, then DA00 to FC72
// - Lock status read only, accepts DA00 write
// - Write 0FB when unlocked opens window
// - Open window allows access to F0000-F0FFF
// - Write 0F9 closes window, normal segment handling
// - Bypass changes need the window open
// - Write 0EC sets bypass, read clears
// - Bypass blocks IRQ13 and raw busy
// - With window, 0EE write/read sets/clears A20
// - A20 out is OR of three sources
// - Window plus 0EF read: 16 cycle reset
// - Reset out ORs fast, hot, keyboard resets
// - 0F2 bit6 selects parity, window gated
// - Parity write drives chip select 1F
// - C472 bit13 selects power interrupt mode
// - C472 bit15: clock changes request shift first
// - With bit15 set, clock change only after grant sampled; with it clear the change is immediate
// - CC72 bit1 selects internal interrupt end
`timescale 1ns/1ps
`default_nettype none
module sfp_top
	import sfp_pkg::*;
#(
	parameter int RST_LEN = QUICK_RST_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] io_addr,
	input  wire logic [15:0] io_wdata,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	output logic      [15:0] io_rdata_q,
	input  wire logic [23:0] mem_addr,
	input  wire logic        mem_onboard_wr,
	output logic             window_hit_q,
	output logic             parity_invert_q,
	output logic      [4:0]  cs_code_q,
	input  wire logic        coproc_error_in,
	input  wire logic        coproc_busy_in,
	output logic             irq13_q,
	output logic             coproc_busy_to_processor_q,
	input  wire logic        kbc_a20_gate_in,
	input  wire logic        port92_a20,
	output logic             a20_gate_q,
	input  wire logic        kbc_reset_in,
	input  wire logic        port92_hot_reset,
	output logic             cpu_reset_q,
	input  wire logic        auto_speedup_req,
	input  wire logic        freq_shift_grant,
	output logic             freq_shift_request_q,
	output logic             clk_change_q,
	output logic             power_interrupt_mode_q,
	output logic             internal_intr_end_select_q
);
	// ============================================================
	// Decode helpers
	function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
		hit = (a == p);
	endfunction

	function automatic logic in_window(input logic [23:0] a);
		in_window = (a >= WIN_LOW_ADDR) && (a <= WIN_HIGH_ADDR);
	endfunction

	// ============================================================
	// Pin synchronisers
	logic [3:0] pins_s;
	sfp_sync #(.W(4)) u_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in ({coproc_error_in, coproc_busy_in, kbc_a20_gate_in, freq_shift_grant}),
		.sync_out (pins_s)
	);
	logic err_s;
	logic busy_s;
	logic kbc_a20_s;
	logic grant_s;
	assign err_s     = pins_s[3];
	assign busy_s    = pins_s[2];
	assign kbc_a20_s = pins_s[1];
	assign grant_s   = pins_s[0];

	// Keyboard reset comes from a pin too
	logic kbc_rst_s;
	sfp_sync #(.W(1)) u_sync_rst (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in (kbc_reset_in),
		.sync_out (kbc_rst_s)
	);

	// ============================================================
	// Unlock sequence
	logic key_seen_q;
	logic unlocked_q;
	logic wr_key;
	logic wr_conf;
	assign wr_key  = io_wr && hit(io_addr, PORT_UNLOCK_KEY);
	assign wr_conf = io_wr && hit(io_addr, PORT_LOCK_STATE);

	// Key must be followed by the confirm word; any other key write relocks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			key_seen_q <= 1'b0;
			unlocked_q <= 1'b0;
		end else if (wr_key) begin
			key_seen_q <= (io_wdata[7:0] == UNLOCK_KEY_VAL);
			if (io_wdata[7:0] != UNLOCK_KEY_VAL)
				unlocked_q <= 1'b0;
		end else if (wr_conf) begin
			// Only DA00 is accepted; other writes leave state alone
			if (key_seen_q && io_wdata == UNLOCK_CONF_VAL) begin
				unlocked_q <= 1'b1;
				key_seen_q <= 1'b0;
			end
		end
	end

	// ============================================================
	// Gated feature strobes; nothing fires while locked
	logic fw;
	logic fr;
	assign fw = io_wr && unlocked_q;
	assign fr = io_rd && unlocked_q;

	logic window_q;
	logic w_open;
	logic w_close;
	assign w_open  = fw && hit(io_addr, PORT_WIN_OPEN);
	assign w_close = fw && hit(io_addr, PORT_WIN_CLOSE);

	// Protected window state; data written is ignored
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			window_q <= 1'b0;
		else if (w_open)
			window_q <= 1'b1;
		else if (w_close)
			window_q <= 1'b0;
	end

	// Window decode for the memory controller
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			window_hit_q <= 1'b0;
		else
			window_hit_q <= window_q && in_window(mem_addr);
	end

	// ============================================================
	// Window gated strobes
	logic pw;
	logic pr;
	assign pw = fw && window_q;
	assign pr = fr && window_q;

	// Coprocessor bypass
	logic bypass_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			bypass_q <= 1'b0;
		else if (pw && hit(io_addr, PORT_BYPASS))
			bypass_q <= 1'b1;
		else if (pr && hit(io_addr, PORT_BYPASS))
			bypass_q <= 1'b0;
	end

	// Bypass masks the error interrupt and holds busy low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq13_q                    <= 1'b0;
			coproc_busy_to_processor_q <= 1'b0;
		end else begin
			irq13_q                    <= err_s && !bypass_q;
			coproc_busy_to_processor_q <= busy_s && !bypass_q;
		end
	end

	// ============================================================
	// Fast A20 gate
	logic fast_a20_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			fast_a20_q <= 1'b0;
		else if (pw && hit(io_addr, PORT_FAST_A20))
			fast_a20_q <= 1'b1;
		else if (pr && hit(io_addr, PORT_FAST_A20))
			fast_a20_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a20_gate_q <= 1'b0;
		else
			a20_gate_q <= fast_a20_q || kbc_a20_s || port92_a20;
	end

	// ============================================================
	// Quick processor reset
	logic rst_start;
	logic rst_pulse;
	assign rst_start = pr && hit(io_addr, PORT_QUICK_RST);
	sfp_pulse #(.LEN(RST_LEN)) u_pulse (
		.clk     (clk),
		.arst_n  (arst_n),
		.start   (rst_start),
		.pulse_q (rst_pulse)
	);

	// The pulse is a flop, so the OR adds one more stage of delay
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cpu_reset_q <= 1'b0;
		else
			cpu_reset_q <= rst_pulse || port92_hot_reset || kbc_rst_s;
	end

	// ============================================================
	// Parity polarity and chip select side effect
	logic par_wr;
	assign par_wr = pw && hit(io_addr, PORT_PARITY);

	// Inversion applies to one write only, then normal parity resumes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			parity_invert_q <= 1'b0;
		else if (par_wr)
			parity_invert_q <= !io_wdata[PARITY_SEL_BIT];
		else if (mem_onboard_wr)
			parity_invert_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cs_code_q <= CS_IDLE_CODE;
		else
			cs_code_q <= par_wr ? CS_PARITY_CODE : CS_IDLE_CODE;
	end

	// ============================================================
	// Mode bits in cache control and region two registers
	logic fs_en_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fs_en_q                <= CTRL_BIT_RST;
			power_interrupt_mode_q <= CTRL_BIT_RST;
		end else if (fw && hit(io_addr, PORT_CACHE_CTRL)) begin
			fs_en_q                <= io_wdata[FREQ_SHIFT_BIT];
			power_interrupt_mode_q <= io_wdata[PWR_INTR_BIT];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			internal_intr_end_select_q <= CTRL_BIT_RST;
		else if (fw && hit(io_addr, PORT_REGION2))
			internal_intr_end_select_q <= io_wdata[INTR_END_BIT];
	end

	// ============================================================
	// Frequency shift handshake
	logic    chg_req;
	sfp_fs_e fs_q;
	sfp_fs_e fs_d;
	assign chg_req = auto_speedup_req || (fw && hit(io_addr, PORT_CLK_CTRL));

	// Requests arriving mid handshake are absorbed into the current change
	always_comb begin
		fs_d = fs_q;
		case (fs_q)
			FS_IDLE: begin
				if (chg_req)
					fs_d = fs_en_q ? FS_WAIT : FS_APPLY;
			end
			FS_WAIT: begin
				if (grant_s)
					fs_d = FS_APPLY;
			end
			FS_APPLY: fs_d = FS_IDLE;
			default:  fs_d = FS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			fs_q <= FS_IDLE;
		else
			fs_q <= fs_d;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			freq_shift_request_q <= 1'b0;
			clk_change_q         <= 1'b0;
		end else begin
			freq_shift_request_q <= (fs_d == FS_WAIT);
			clk_change_q         <= (fs_d == FS_APPLY);
		end
	end

	// ============================================================
	// Read data; strobe ports and unmapped addresses read zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			io_rdata_q <= RDATA_ZERO;
		else if (io_rd) begin
			io_rdata_q <= RDATA_ZERO;
			if (hit(io_addr, PORT_LOCK_STATE))
				io_rdata_q[LOCK_STATE_BIT] <= unlocked_q;
			else if (unlocked_q && hit(io_addr, PORT_CACHE_CTRL)) begin
				io_rdata_q[FREQ_SHIFT_BIT] <= fs_en_q;
				io_rdata_q[PWR_INTR_BIT]   <= power_interrupt_mode_q;
			end else if (unlocked_q && hit(io_addr, PORT_REGION2))
				io_rdata_q[INTR_END_BIT] <= internal_intr_end_select_q;
		end
	end

	// ============================================================
	// Checks
	sequence s_key;
		wr_key && io_wdata[7:0] == UNLOCK_KEY_VAL;
	endsequence
	sequence s_conf;
		wr_conf && io_wdata == UNLOCK_CONF_VAL;
	endsequence

	a_unlock_needs_key: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(unlocked_q) |-> $past(key_seen_q && wr_conf && io_wdata == UNLOCK_CONF_VAL))
		else $error("unlock without key then confirm");
	a_unlock_seq: assert property (@(posedge clk) disable iff (!arst_n)
		s_key ##1 !wr_key ##1 s_conf |=> unlocked_q)
		else $error("valid unlock sequence ignored");
	a_locked_ignores: assert property (@(posedge clk) disable iff (!arst_n)
		(!unlocked_q && !window_q) |=> !window_q)
		else $error("window opened while locked");
	a_window_open: assert property (@(posedge clk) disable iff (!arst_n)
		w_open |=> window_q)
		else $error("window did not open");
	a_window_close: assert property (@(posedge clk) disable iff (!arst_n)
		w_close && !w_open |=> !window_q ##1 !window_hit_q)
		else $error("window did not close");
	a_window_hit: assert property (@(posedge clk) disable iff (!arst_n)
		window_q && in_window(mem_addr) |=> window_hit_q)
		else $error("window access refused");
	a_bypass_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!window_q && !bypass_q |=> !bypass_q)
		else $error("bypass set without window");
	a_bypass_irq: assert property (@(posedge clk) disable iff (!arst_n)
		bypass_q && $past(bypass_q) |=> !irq13_q && !coproc_busy_to_processor_q)
		else $error("bypass did not mask coprocessor");
	a_bypass_read: assert property (@(posedge clk) disable iff (!arst_n)
		pr && hit(io_addr, PORT_BYPASS) |=> !bypass_q)
		else $error("bypass read did not clear");
	a_a20_or: assert property (@(posedge clk) disable iff (!arst_n)
		(fast_a20_q || kbc_a20_s || port92_a20) |=> a20_gate_q)
		else $error("a20 gate missing source");
	a_a20_write: assert property (@(posedge clk) disable iff (!arst_n)
		pw && hit(io_addr, PORT_FAST_A20) |=> fast_a20_q ##1 a20_gate_q)
		else $error("fast a20 not enabled");
	a_reset_len: assert property (@(posedge clk) disable iff (!arst_n)
		rst_start ##1 !rst_start [*8] |-> rst_pulse)
		else $error("reset pulse too short");
	a_reset_end: assert property (@(posedge clk) disable iff (!arst_n)
		rst_start ##1 !rst_start [*8] ##1 !rst_start [*7] ##1 !rst_start |=> !rst_pulse)
		else $error("reset pulse too long");
	a_reset_or: assert property (@(posedge clk) disable iff (!arst_n)
		(rst_pulse || port92_hot_reset || kbc_rst_s) |=> cpu_reset_q)
		else $error("processor reset missing source");
	a_parity_sel: assert property (@(posedge clk) disable iff (!arst_n)
		par_wr |=> parity_invert_q == !$past(io_wdata[PARITY_SEL_BIT]))
		else $error("parity select wrong");
	a_parity_cs: assert property (@(posedge clk) disable iff (!arst_n)
		par_wr |=> cs_code_q == CS_PARITY_CODE ##1 cs_code_q == CS_IDLE_CODE || $past(par_wr))
		else $error("chip select code not driven");
	a_shift_req: assert property (@(posedge clk) disable iff (!arst_n)
		fs_q == FS_IDLE && chg_req && fs_en_q |=> freq_shift_request_q && !clk_change_q)
		else $error("clock change without shift request");
	a_shift_grant: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(clk_change_q) && $past(fs_q) == FS_WAIT |-> $past(grant_s))
		else $error("clock changed before grant");
	a_mode_bits: assert property (@(posedge clk) disable iff (!arst_n)
		fw && hit(io_addr, PORT_CACHE_CTRL) |=> power_interrupt_mode_q == $past(io_wdata[PWR_INTR_BIT]))
		else $error("interrupt mode bit not stored");
	a_end_select: assert property (@(posedge clk) disable iff (!arst_n)
		fw && hit(io_addr, PORT_REGION2) |=> internal_intr_end_select_q == $past(io_wdata[INTR_END_BIT]))
		else $error("interrupt end select not stored");
endmodule // sfp_top
`default_nettype wire

// file: test/sfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Processor side of the clock shift handshake
module sfp_host_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       freq_shift_request_q,
	input  wire logic [7:0] gnt_dly,
	output logic            freq_shift_grant
);
	logic [7:0] wait_q;

	// Grant after a chosen delay, dropped as soon as the request goes away
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_q           <= 8'h00;
			freq_shift_grant <= 1'b0;
		end else if (!freq_shift_request_q) begin
			wait_q           <= 8'h00;
			freq_shift_grant <= 1'b0;
		end else if (wait_q >= gnt_dly) begin
			freq_shift_grant <= 1'b1;
		end else begin
			wait_q <= wait_q + 8'h01;
		end
	end
endmodule // sfp_host_model
`default_nettype wire

// file: test/special_feature_ports_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module special_feature_ports_tb_top import sfp_pkg::*;;
	localparam int RLEN = QUICK_RST_CYCLES;
	logic        clk, arst_n, io_wr, io_rd, mem_wr, err_in, busy_in, kbc_a20, p92_a20, kbc_rst, hot_rst, auto_req;
	logic [15:0] io_addr, io_wdata, rdata, d;
	logic [23:0] mem_addr;
	logic        hit, par_inv, irq13, busy_out, a20, cpu_rst, fs_req, fs_gnt, clk_chg, pwr_mode, end_sel;
	logic [4:0]  cs_code;
	logic [7:0]  gnt_dly;
	int          err_total, tests_run, cyc, seed, n, rq, gt, cg;

	sfp_top #(.RST_LEN(RLEN)) uut (.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_wr(io_wr), .io_rd(io_rd), .io_rdata_q(rdata), .mem_addr(mem_addr), .mem_onboard_wr(mem_wr),
		.window_hit_q(hit), .parity_invert_q(par_inv), .cs_code_q(cs_code), .coproc_error_in(err_in),
		.coproc_busy_in(busy_in), .irq13_q(irq13), .coproc_busy_to_processor_q(busy_out),
		.kbc_a20_gate_in(kbc_a20), .port92_a20(p92_a20), .a20_gate_q(a20), .kbc_reset_in(kbc_rst),
		.port92_hot_reset(hot_rst), .cpu_reset_q(cpu_rst), .auto_speedup_req(auto_req),
		.freq_shift_grant(fs_gnt), .freq_shift_request_q(fs_req), .clk_change_q(clk_chg),
		.power_interrupt_mode_q(pwr_mode), .internal_intr_end_select_q(end_sel));

	sfp_host_model host (.clk(clk), .arst_n(arst_n), .freq_shift_request_q(fs_req), .gnt_dly(gnt_dly),
		.freq_shift_grant(fs_gnt));

	// ============================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Whole run needs about 380 cycles, so 20000 leaves room without hiding a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc >= 20000) begin
			err_total++;
			wrap_up();
		end
	end

	// ============================================================
	// Bench helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask

	// One I/O write, held for exactly one sampling edge
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(negedge clk);
		io_addr  = a;
		io_wdata = v;
		io_wr    = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
	endtask

	// One I/O read; data is settled by the negedge after the taking edge
	task automatic rdp(input logic [15:0] a);
		@(negedge clk);
		io_addr = a;
		io_rd   = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
	endtask

	task automatic pulse_mem();
		@(negedge clk);
		mem_wr = 1'b1;
		@(negedge clk);
		mem_wr = 1'b0;
	endtask

	function automatic logic exp_hit(input logic w, input logic [23:0] a);
		return w && (a >= WIN_LOW_ADDR) && (a <= WIN_HIGH_ADDR);
	endfunction

	// Edges of the window plus one random address inside it
	task automatic probe_win(input logic w);
		logic [23:0] pa [0:4];
		pa = '{WIN_LOW_ADDR, WIN_HIGH_ADDR, WIN_HIGH_ADDR + 24'h1, WIN_LOW_ADDR - 24'h1, 24'h0};
		pa[4] = WIN_LOW_ADDR + (24'($random(seed)) & 24'h000fff);
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			mem_addr = pa[i];
			tick(1);
			check("window hit", 16'(hit), 16'(exp_hit(w, pa[i])));
		end
	endtask

	// Fire one clock change request and log when each handshake step shows
	task automatic shift_run(input logic via_port);
		if (via_port) begin
			wr(PORT_CLK_CTRL, 16'($random(seed)));
		end else begin
			@(negedge clk);
			auto_req = 1'b1;
			@(negedge clk);
			auto_req = 1'b0;
		end
		rq = 99;
		gt = 99;
		cg = 99;
		// Sample first: with the handshake off the change pulse stands only one cycle
		for (int i = 0; i < 60; i++) begin
			if (fs_req && rq == 99) rq = i;
			if (fs_gnt && gt == 99) gt = i;
			if (clk_chg && cg == 99) cg = i;
			@(negedge clk);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ============================================================
	// Main sequence
	initial begin
		{io_wr, io_rd, mem_wr, err_in, busy_in, kbc_a20, p92_a20, kbc_rst, hot_rst, auto_req} = '0;
		io_addr = 16'h0000;
		io_wdata = 16'h0000;
		mem_addr = 24'h000000;
		gnt_dly = 8'h00;
		seed = 32'hcfa803b1;
		arst_n = 1'b0;
		tick(4);
		arst_n = 1'b1;
		check("reset outs", {hit, par_inv, irq13, busy_out, a20, cpu_rst, fs_req, clk_chg, pwr_mode, end_sel, cs_code},
			16'h0000);
		err_in = 1'b1;
		busy_in = 1'b1;
		$display("test reset done");

		// Locked part: feature ports must do nothing, a lone confirm word must not unlock
		wr(PORT_WIN_OPEN, 16'($random(seed)));
		wr(PORT_FAST_A20, 16'($random(seed)));
		rdp(PORT_QUICK_RST);
		wr(PORT_CACHE_CTRL, 16'ha002);
		wr(PORT_LOCK_STATE, UNLOCK_CONF_VAL);
		tick(3);
		check("locked a20", 16'(a20), 16'h0);
		check("locked reset", 16'(cpu_rst), 16'h0);
		check("locked mode", 16'(pwr_mode), 16'h0);
		rdp(PORT_LOCK_STATE);
		check("lock state", rdata, 16'h0000);
		$display("test locked done");

		// Unlock, then a stray write to the status port must not disturb it
		wr(PORT_UNLOCK_KEY, {8'h00, UNLOCK_KEY_VAL});
		wr(PORT_LOCK_STATE, UNLOCK_CONF_VAL);
		rdp(PORT_LOCK_STATE);
		check("unlocked", rdata, 16'h0001);
		wr(PORT_LOCK_STATE, 16'h1234);
		rdp(PORT_LOCK_STATE);
		check("status ro", rdata, 16'h0001);
		$display("test unlock done");

		// Window still closed: gated ports ignored
		wr(PORT_BYPASS, 16'($random(seed)));
		wr(PORT_FAST_A20, 16'($random(seed)));
		rdp(PORT_QUICK_RST);
		wr(PORT_PARITY, 16'h0000);
		tick(2);
		check("closed bypass", 16'(irq13), 16'h1);
		check("closed a20", 16'(a20), 16'h0);
		check("closed rst", 16'(cpu_rst), 16'h0);
		check("closed par", {par_inv, cs_code}, 16'h0);
		probe_win(1'b0);
		wr(PORT_WIN_OPEN, 16'($random(seed)));
		probe_win(1'b1);
		$display("test window done");

		// Bypass on by write, off by read
		wr(PORT_BYPASS, 16'($random(seed)));
		tick(1);
		check("bypass on", {irq13, busy_out}, 16'h0);
		rdp(PORT_BYPASS);
		tick(1);
		check("bypass off", {irq13, busy_out}, 16'h3);
		$display("test bypass done");

		// Every mix of the three A20 sources
		for (int k = 0; k < 8; k++) begin
			if (k[0]) wr(PORT_FAST_A20, 16'($random(seed)));
			else rdp(PORT_FAST_A20);
			kbc_a20 = k[1];
			p92_a20 = k[2];
			tick(4);
			check("a20 or", 16'(a20), 16'(k != 0));
		end
		$display("test a20 done");

		// Fast reset length, then the other two reset sources
		rdp(PORT_QUICK_RST);
		n = 0;
		for (int i = 0; i < 30; i++) begin
			@(negedge clk);
			if (cpu_rst === 1'b1) n++;
		end
		check("rst len", 16'(n), 16'(RLEN));
		hot_rst = 1'b1;
		tick(2);
		check("hot rst", 16'(cpu_rst), 16'h1);
		hot_rst = 1'b0;
		kbc_rst = 1'b1;
		tick(4);
		check("kbc rst", 16'(cpu_rst), 16'h1);
		kbc_rst = 1'b0;
		tick(4);
		check("rst idle", 16'(cpu_rst), 16'h0);
		$display("test reset out done");

		// Parity inversion is one-shot; select code shows for one cycle
		wr(PORT_PARITY, 16'($random(seed)) & 16'hffbf);
		check("cs code", {par_inv, cs_code}, 16'h3f);
		tick(1);
		check("cs idle", {par_inv, cs_code}, 16'h20);
		pulse_mem();
		tick(1);
		check("par used", 16'(par_inv), 16'h0);
		wr(PORT_PARITY, 16'h0000);
		wr(PORT_PARITY, 16'h0040);
		tick(1);
		check("par normal", 16'(par_inv), 16'h0);
		wr(PORT_WIN_CLOSE, 16'($random(seed)));
		probe_win(1'b0);
		$display("test parity done");

		// Mode bits and their read-back
		d = (16'($random(seed)) | 16'h2000) & 16'h7fff;
		wr(PORT_CACHE_CTRL, d);
		rdp(PORT_CACHE_CTRL);
		check("pwr mode", 16'(pwr_mode), 16'h1);
		check("c472 read", rdata, d & 16'ha000);
		wr(PORT_REGION2, 16'($random(seed)) | 16'h0002);
		rdp(PORT_REGION2);
		check("end sel", 16'(end_sel), 16'h0001);
		check("cc72 read", rdata, 16'h0002);
		$display("test modes done");

		// Clock change with the handshake off: immediate, no request
		shift_run(1'b0);
		check("direct chg", 16'((rq == 99) && (cg < 99)), 16'h1);
		wr(PORT_CACHE_CTRL, 16'h8000);
		for (int j = 0; j < 2; j++) begin
			gnt_dly = j ? 8'(5 + ($random(seed) & 15)) : 8'h00;
			shift_run(j[0]);
			check("shift req", 16'(rq < gt), 16'h1);
			check("shift order", 16'((gt < 99) && (cg > gt) && (cg < 99)), 16'h1);
			check("req drop", 16'(fs_req), 16'h0);
		end
		$display("test freq shift done");
		wrap_up();
	end
endmodule // special_feature_ports_tb_top
`default_nettype wire
